// ===== inc/lane_pkg.sv
// shared constants, enums and carrier structs for the packed lane datapath
`default_nettype none
package lane_pkg;
	// lane geometry
	localparam int WORD_W = 32;
	localparam int BYTE_W = 8;
	localparam int HALF_W = 16;
	localparam int BYTE_LANES = WORD_W / BYTE_W;
	localparam int HALF_LANES = WORD_W / HALF_W;
	// shift amount bits kept per lane width (modulo lane width)
	localparam int BYTE_AMT_W = 3;
	localparam int HALF_AMT_W = 4;
	// instruction field widths
	localparam int MAJOR_W = 3;
	localparam int EXT_W = 9;
	localparam int IMMEDIATE_SHIFT_COUNT_W = 5;
	localparam int DEST_W = 6;
	// slot zero encodings of the two saturating subtracts
	localparam logic [MAJOR_W-1:0] MAJOR_RRR = 3'h0;
	localparam logic [EXT_W-1:0] EXT_SUBBS_U = 9'h064;
	localparam logic [EXT_W-1:0] EXT_SUBHS = 9'h065;
	// reset values
	localparam logic [WORD_W-1:0] DATA_RST = 32'h0000_0000;
	localparam logic [DEST_W-1:0] DEST_RST = 6'h00;

	// issue slots: two wide, three narrow
	typedef enum logic [2:0] {
		SLOT_WIDE0 = 3'h0,
		SLOT_WIDE1 = 3'h1,
		SLOT_NARROW0 = 3'h2,
		SLOT_NARROW1 = 3'h3,
		SLOT_NARROW2 = 3'h4
	} slot_t;

	// operations carried out by the block
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_NE_B = 4'h1,
		OP_NE_H = 4'h2,
		OP_SRA_B = 4'h3,
		OP_SRA_H = 4'h4,
		OP_SRAI_B = 4'h5,
		OP_SRAI_H = 4'h6,
		OP_SUB_B = 4'h7,
		OP_SUBS_BU = 4'h8,
		OP_SUB_H = 4'h9,
		OP_SUBS_H = 4'ha
	} op_t;

	// one issued instruction with its operands
	typedef struct packed {
		logic valid;
		slot_t slot;
		op_t op;
		logic [MAJOR_W-1:0] major_op_field_slot_zero;
		logic [EXT_W-1:0] three_reg_ext_field_slot_zero;
		logic [IMMEDIATE_SHIFT_COUNT_W-1:0] immediate_shift_count;
		logic [DEST_W-1:0] dest;
		logic [WORD_W-1:0] first_operand;
		logic [WORD_W-1:0] second_operand;
	} issue_req_t;

	// write-back to the register file
	typedef struct packed {
		logic valid;
		logic [DEST_W-1:0] dest;
		logic [WORD_W-1:0] data;
	} result_t;
endpackage
`default_nettype wire

// ===== verilog/lane_unit.sv
// one lane of the packed datapath: compare, shift and three subtracts
`timescale 1ns/10ps
`default_nettype none
module lane_unit #(
	parameter int W = 8,
	parameter int AW = 3
) (
	input wire logic [W-1:0] a_i,
	input wire logic [W-1:0] b_i,
	input wire logic [AW-1:0] amt_i,
	output logic ne_o,
	output logic [W-1:0] sra_o,
	output logic [W-1:0] sub_o,
	output logic [W-1:0] subu_sat_o,
	output logic [W-1:0] subs_sat_o
);
	// one extra bit catches borrow and signed overflow inside this lane only
	logic [W:0] udiff;
	logic [W:0] sdiff;

	// all results are local to the lane, nothing leaves through a carry
	always_comb begin
		udiff = {1'b0, a_i} - {1'b0, b_i};
		sdiff = {a_i[W-1], a_i} - {b_i[W-1], b_i};
		ne_o = (a_i != b_i);
		// sign fill comes from this lane's own top bit
		sra_o = W'($signed(a_i) >>> amt_i);
		sub_o = udiff[W-1:0];
		// a borrow out means the true result went below zero
		subu_sat_o = udiff[W] ? {W{1'b0}} : udiff[W-1:0];
		// top two bits disagree only on signed overflow
		if (sdiff[W] != sdiff[W-1]) begin
			subs_sat_o = sdiff[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
		end else begin
			subs_sat_o = sdiff[W-1:0];
		end
	end
endmodule
`default_nettype wire

// ===== verilog/packed_lane_compare_shift_subtract.sv
// packed lane compare, arithmetic shift and subtract datapath for the wide slots
// Summary of operation
// [RL1] byte lanes set 1 when bytes differ
// [RL2] half lanes set 1 when halves differ
// [RL3] byte arithmetic shift by register, modulo eight
// [RL4] half arithmetic shift by register, modulo sixteen
// [RL5] byte arithmetic shift by immediate, modulo eight
// [RL6] half arithmetic shift by immediate, modulo sixteen
// [RL7] byte subtract wraps within each lane
// [RL8] unsigned byte subtract clamps at zero
// [RL9] half subtract wraps within each lane
// [RL10] signed half subtract clamps to signed range
// [RL11] slot zero major 0x0, ext 0x64: byte saturating
// [RL12] slot zero major 0x0, ext 0x65: half saturating
// [RL13] only the two wide slots are accepted
// [RL14] nothing crosses a lane boundary
`timescale 1ns/10ps
`default_nettype none
module packed_lane_compare_shift_subtract (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire lane_pkg::issue_req_t req_i,
	output lane_pkg::result_t resp_o,
	output logic reject_o
);
	import lane_pkg::*;

	// decoded operation and acceptance of the current request
	op_t op_dec;
	logic wide_slot;
	logic accept;

	// shift amounts after the modulo, one per lane width
	logic [BYTE_AMT_W-1:0] amt_b;
	logic [HALF_AMT_W-1:0] amt_h;

	// per lane results, gathered into words
	logic [BYTE_LANES-1:0] ne_b;
	logic [HALF_LANES-1:0] ne_h;
	logic [WORD_W-1:0] sra_b;
	logic [WORD_W-1:0] sra_h;
	logic [WORD_W-1:0] sub_b;
	logic [WORD_W-1:0] subu_b;
	logic [WORD_W-1:0] sub_h;
	logic [WORD_W-1:0] subs_h;

	// registered write-back state
	result_t res_reg;
	result_t res_next;
	op_t op_reg;
	op_t op_next;
	logic reject_reg;
	logic reject_next;
	// word formed for the current request
	logic [WORD_W-1:0] word;

	// slot and opcode decode
	always_comb begin
		// narrow slots are never accepted by this datapath
		wide_slot = (req_i.slot == SLOT_WIDE0) || (req_i.slot == SLOT_WIDE1); // RL13
		op_dec = req_i.op;
		// slot zero carries raw fields for the saturating subtracts
		if (req_i.slot == SLOT_WIDE0 && req_i.major_op_field_slot_zero == MAJOR_RRR) begin
			if (req_i.three_reg_ext_field_slot_zero == EXT_SUBBS_U) begin
				op_dec = OP_SUBS_BU; // RL11
			end else if (req_i.three_reg_ext_field_slot_zero == EXT_SUBHS) begin
				op_dec = OP_SUBS_H; // RL12
			end
		end
		accept = req_i.valid && wide_slot && (op_dec != OP_NONE); // RL13
	end

	// shift amount select: register operand or immediate, both taken modulo
	always_comb begin
		if (op_dec == OP_SRAI_B || op_dec == OP_SRAI_H) begin
			amt_b = req_i.immediate_shift_count[BYTE_AMT_W-1:0]; // RL5
			amt_h = req_i.immediate_shift_count[HALF_AMT_W-1:0]; // RL6
		end else begin
			amt_b = req_i.second_operand[BYTE_AMT_W-1:0]; // RL3
			amt_h = req_i.second_operand[HALF_AMT_W-1:0]; // RL4
		end
	end

	// four independent byte lanes
	genvar gb;
	generate
		for (gb = 0; gb < BYTE_LANES; gb++) begin : g_byte
			// separate instances keep borrow and sign inside the lane
			lane_unit #(
				.W(BYTE_W),
				.AW(BYTE_AMT_W)
			) u_lane (
				.a_i(req_i.first_operand[gb*BYTE_W +: BYTE_W]),
				.b_i(req_i.second_operand[gb*BYTE_W +: BYTE_W]),
				.amt_i(amt_b),
				.ne_o(ne_b[gb]),
				.sra_o(sra_b[gb*BYTE_W +: BYTE_W]),
				.sub_o(sub_b[gb*BYTE_W +: BYTE_W]),
				.subu_sat_o(subu_b[gb*BYTE_W +: BYTE_W]),
				.subs_sat_o()
			); // RL14
		end
	endgenerate

	// two independent half word lanes
	genvar gh;
	generate
		for (gh = 0; gh < HALF_LANES; gh++) begin : g_half
			lane_unit #(
				.W(HALF_W),
				.AW(HALF_AMT_W)
			) u_lane (
				.a_i(req_i.first_operand[gh*HALF_W +: HALF_W]),
				.b_i(req_i.second_operand[gh*HALF_W +: HALF_W]),
				.amt_i(amt_h),
				.ne_o(ne_h[gh]),
				.sra_o(sra_h[gh*HALF_W +: HALF_W]),
				.sub_o(sub_h[gh*HALF_W +: HALF_W]),
				.subu_sat_o(),
				.subs_sat_o(subs_h[gh*HALF_W +: HALF_W])
			); // RL14
		end
	endgenerate

	// result select and next write-back state
	always_comb begin
		word = DATA_RST;
		case (op_dec)
			OP_NE_B: begin
				// each byte lane holds 0 or 1
				for (int i = 0; i < BYTE_LANES; i++) begin
					word[i*BYTE_W] = ne_b[i]; // RL1
				end
			end
			OP_NE_H: begin
				for (int i = 0; i < HALF_LANES; i++) begin
					word[i*HALF_W] = ne_h[i]; // RL2
				end
			end
			OP_SRA_B, OP_SRAI_B: begin
				word = sra_b; // RL3 RL5
			end
			OP_SRA_H, OP_SRAI_H: begin
				word = sra_h; // RL4 RL6
			end
			OP_SUB_B: begin
				word = sub_b; // RL7
			end
			OP_SUBS_BU: begin
				word = subu_b; // RL8
			end
			OP_SUB_H: begin
				word = sub_h; // RL9
			end
			OP_SUBS_H: begin
				word = subs_h; // RL10
			end
			default: begin
				word = DATA_RST;
			end
		endcase
		// data and destination hold their last value when idle
		res_next = res_reg;
		res_next.valid = accept;
		op_next = op_reg;
		if (accept) begin
			res_next.data = word;
			res_next.dest = req_i.dest;
			op_next = op_dec;
		end
		// a refused request is flagged, never written back
		reject_next = req_i.valid && !accept; // RL13
	end

	// one pipeline stage; synchronous reset clears the write-back
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			res_reg <= '{valid: 1'b0, dest: DEST_RST, data: DATA_RST};
			op_reg <= OP_NONE;
			reject_reg <= 1'b0;
		end else begin
			res_reg <= res_next;
			op_reg <= op_next;
			reject_reg <= reject_next;
		end
	end

	assign resp_o = res_reg;
	assign reject_o = reject_reg;

	// checks: each ties a write-back to the request one cycle before
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	// previous operands, shorthand for the checks below
	logic [WORD_W-1:0] pa;
	logic [WORD_W-1:0] pb;
	logic [IMMEDIATE_SHIFT_COUNT_W-1:0] pi;
	// capture at the taking edge, so they line up with the write-back one edge later
	always_ff @(posedge sys_clk_i) begin
		pa <= req_i.first_operand;
		pb <= req_i.second_operand;
		pi <= req_i.immediate_shift_count;
	end

	ne_byte_a: assert property (resp_o.valid && op_reg == OP_NE_B |-> // RL1
		resp_o.data == {7'h00, pa[31:24] != pb[31:24], 7'h00, pa[23:16] != pb[23:16],
		7'h00, pa[15:8] != pb[15:8], 7'h00, pa[7:0] != pb[7:0]})
		else $error("byte not-equal result wrong");

	ne_half_a: assert property (resp_o.valid && op_reg == OP_NE_H |-> // RL2
		resp_o.data == {15'h0000, pa[31:16] != pb[31:16], 15'h0000, pa[15:0] != pb[15:0]})
		else $error("half not-equal result wrong");

	sra_byte_a: assert property (resp_o.valid && op_reg == OP_SRA_B |-> // RL3
		resp_o.data[31:24] == 8'($signed(pa[31:24]) >>> pb[2:0]))
		else $error("byte register shift wrong");

	sra_half_a: assert property (resp_o.valid && op_reg == OP_SRA_H |-> // RL4
		resp_o.data[15:0] == 16'($signed(pa[15:0]) >>> pb[3:0]))
		else $error("half register shift wrong");

	srai_byte_a: assert property (resp_o.valid && op_reg == OP_SRAI_B |-> // RL5
		resp_o.data[15:8] == 8'($signed(pa[15:8]) >>> pi[2:0]))
		else $error("byte immediate shift wrong");

	srai_half_a: assert property (resp_o.valid && op_reg == OP_SRAI_H |-> // RL6
		resp_o.data[31:16] == 16'($signed(pa[31:16]) >>> pi[3:0]))
		else $error("half immediate shift wrong");

	sub_byte_a: assert property (resp_o.valid && op_reg == OP_SUB_B |-> // RL7
		resp_o.data[23:16] == 8'(pa[23:16] - pb[23:16]))
		else $error("byte subtract wrong");

	sat_byte_a: assert property (resp_o.valid && op_reg == OP_SUBS_BU |-> // RL8
		resp_o.data[7:0] == ((pa[7:0] < pb[7:0]) ? 8'h00 : 8'(pa[7:0] - pb[7:0])))
		else $error("unsigned byte clamp wrong");

	sub_half_a: assert property (resp_o.valid && op_reg == OP_SUB_H |-> // RL9
		resp_o.data == {16'(pa[31:16] - pb[31:16]), 16'(pa[15:0] - pb[15:0])})
		else $error("half subtract wrong");

	sat_half_a: assert property (resp_o.valid && op_reg == OP_SUBS_H && // RL10
		($signed({pa[31], pa[31:16]}) - $signed({pb[31], pb[31:16]})) > 17'sh07fff |->
		resp_o.data[31:16] == 16'h7fff)
		else $error("signed half clamp wrong");

	decode_sat_a: assert property (req_i.valid && req_i.slot == SLOT_WIDE0 && // RL11
		req_i.major_op_field_slot_zero == MAJOR_RRR &&
		req_i.three_reg_ext_field_slot_zero == EXT_SUBBS_U |=>
		resp_o.valid && op_reg == OP_SUBS_BU)
		else $error("byte saturating decode missed");

	decode_half_a: assert property (req_i.valid && req_i.slot == SLOT_WIDE0 && // RL12
		req_i.major_op_field_slot_zero == MAJOR_RRR &&
		req_i.three_reg_ext_field_slot_zero == EXT_SUBHS |=>
		resp_o.valid && op_reg == OP_SUBS_H)
		else $error("half saturating decode missed");

	narrow_slot_a: assert property (req_i.valid && // RL13
		!(req_i.slot inside {SLOT_WIDE0, SLOT_WIDE1}) |=> reject_o && !resp_o.valid)
		else $error("narrow slot was accepted");

	lane_iso_a: assert property (resp_o.valid && op_reg == OP_SUB_B && // RL14
		pa[7:0] < pb[7:0] |-> resp_o.data[15:8] == 8'(pa[15:8] - pb[15:8]))
		else $error("borrow crossed a byte lane");

	// main scenarios
	cov_sat_clamp: cover property (resp_o.valid && op_reg == OP_SUBS_BU && resp_o.data == DATA_RST);
	cov_back2back: cover property (resp_o.valid ##1 resp_o.valid);
	cov_reject: cover property (reject_o ##1 resp_o.valid);
	cov_shift_neg: cover property (resp_o.valid && op_reg == OP_SRA_H && resp_o.data[31]);
endmodule
`default_nettype wire

// ===== test/issue_model.sv
// issue stage model that presents one instruction per cycle to the datapath
`timescale 1ns/10ps
`default_nettype none
module issue_model (
	input wire logic sys_clk_i,
	output lane_pkg::issue_req_t req_o
);
	import lane_pkg::*;
	// nothing issued until the first send
	initial req_o = '0;
	// present one request, launched at a rising edge and held until the next send or idle
	task automatic send(input issue_req_t r);
		@(posedge sys_clk_i);
		req_o <= r;
	endtask
	// empty issue slot; clearing all fields avoids stale operands looking valid
	task automatic idle();
		@(posedge sys_clk_i);
		req_o <= '0;
	endtask
endmodule
`default_nettype wire

// ===== test/packed_lane_compare_shift_subtract_tb.sv
// self-checking bench: issue model drives, integer lane model predicts results
`timescale 1ns/10ps
`default_nettype none
module packed_lane_compare_shift_subtract_tb;
	import lane_pkg::*;
	logic sys_clk_i = 1'b0; // 50 MHz
	logic reset_i = 1'b1; // synchronous, active high
	issue_req_t req; // from issue model
	result_t resp; // write-back
	logic reject; // refusal pulse
	int n_fail = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic armed = 1'b0; // a prediction is pending
	logic pv, pr; // predicted valid and reject
	logic [5:0] hd = '0; // held destination
	logic [31:0] hdata = '0; // held data
	logic [31:0] pairs [4] = '{32'h80ff7f01, 32'h01ff80ff, 32'h7fff8000, 32'hffff0001};
	always #10 sys_clk_i = ~sys_clk_i;
	issue_model pm (.sys_clk_i(sys_clk_i), .req_o(req));
	packed_lane_compare_shift_subtract dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.req_i(req), .resp_o(resp), .reject_o(reject));
	// compare one value and count it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// single closing point of the run
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// slot zero raw fields pick the saturating subtracts, else the op field stands
	function automatic op_t decode(issue_req_t r);
		if (r.slot == SLOT_WIDE0 && r.major_op_field_slot_zero == 3'h0) begin
			if (r.three_reg_ext_field_slot_zero == 9'h064) return OP_SUBS_BU;
			if (r.three_reg_ext_field_slot_zero == 9'h065) return OP_SUBS_H;
		end
		return r.op;
	endfunction
	// signed value of a lane value of width w
	function automatic int sx(int x, int w);
		return (x >= (1 << (w - 1))) ? x - (1 << w) : x;
	endfunction
	// lane by lane reference, no carry between lanes
	function automatic logic [31:0] model(issue_req_t r);
		op_t op;
		int w, a, b, amt, v, m;
		logic [31:0] o;
		op = decode(r);
		w = (op inside {OP_NE_B, OP_SRA_B, OP_SRAI_B, OP_SUB_B, OP_SUBS_BU}) ? 8 : 16;
		m = (1 << w) - 1;
		o = '0;
		amt = (op inside {OP_SRAI_B, OP_SRAI_H}) ? r.immediate_shift_count % w
			: r.second_operand[3:0] % w;
		for (int i = 0; i < 32 / w; i++) begin
			a = int'((r.first_operand >> (i * w))) & m;
			b = int'((r.second_operand >> (i * w))) & m;
			case (op)
				OP_NE_B, OP_NE_H: v = (a != b) ? 1 : 0;
				OP_SRA_B, OP_SRA_H, OP_SRAI_B, OP_SRAI_H: v = sx(a, w) >>> amt;
				OP_SUBS_BU: v = (a < b) ? 0 : a - b;
				OP_SUBS_H: begin
					v = sx(a, w) - sx(b, w);
					v = (v > 32767) ? 32767 : (v < -32768) ? -32768 : v;
				end
				default: v = a - b;
			endcase
			o = o | (32'(v & m) << (i * w));
		end
		return o;
	endfunction
	// build one request; dest is random so the echo is exercised
	function automatic issue_req_t mk(int s, int o, logic [31:0] a, logic [31:0] b,
		logic [4:0] sh, logic [2:0] mj, logic [8:0] ex);
		issue_req_t r;
		r = '{1'b1, slot_t'(s), op_t'(o), mj, ex, sh, 6'($urandom), a, b};
		return r;
	endfunction
	// compare the previous prediction, then predict from what is presented now
	always @(negedge sys_clk_i) begin
		if (armed) begin
			check(32'(resp.valid), 32'(pv));
			check(32'(reject), 32'(pr));
			check(32'(resp.dest), 32'(hd));
			check(resp.data, hdata);
		end
		pv = 1'b0;
		pr = 1'b0;
		if (reset_i) begin
			hd = '0;
			hdata = '0;
		end else if (req.valid) begin
			// narrow slots and empty ops are refused
			if (req.slot > SLOT_WIDE1 || decode(req) == OP_NONE) pr = 1'b1;
			else begin
				pv = 1'b1;
				hd = req.dest;
				hdata = model(req);
			end
		end
		armed = 1'b1;
	end
	// hang guard, far above the expected run length
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(18282));
		repeat (3) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		// every op in both wide slots, lane boundary corner operands
		for (int p = 0; p < 4; p++)
			for (int k = 0; k < 11; k++)
				for (int s = 0; s < 2; s++)
					pm.send(mk(s, k, pairs[p], pairs[(p + 1) % 4], 5'h7, 3'h1, 9'h0));
		// every shift count, register and immediate forms
		for (int k = 0; k < 32; k++)
			for (int o = 3; o < 7; o++)
				pm.send(mk(k % 2, o, 32'h80817f80, 32'(k), 5'(k), 3'h1, 9'h0));
		// narrow slots are refused
		for (int s = 2; s < 5; s++) pm.send(mk(s, 7, 32'h5, 32'h3, 5'h0, 3'h1, 9'h0));
		// raw slot zero decode against slot one and a wrong major field
		for (int s = 0; s < 2; s++)
			for (int mj = 0; mj < 2; mj++)
				for (int e = 9'h063; e < 9'h066; e++) begin
					pm.send(mk(s, 0, pairs[0], pairs[1], 5'h0, 3'(mj), 9'(e)));
					pm.send(mk(s, 1, pairs[2], pairs[3], 5'h0, 3'(mj), 9'(e)));
				end
		// random mix, some idle cycles and refusals
		for (int n = 0; n < 300; n++) begin
			pm.send(mk($urandom_range(4), $urandom_range(10), $urandom, $urandom,
				5'($urandom), 3'($urandom_range(1)), 9'($urandom_range(9'h064, 9'h061))));
			if ($urandom_range(3) == 0) pm.idle();
		end
		// reset arriving together with a request drops it
		fork
			pm.send(mk(1, 7, 32'h9, 32'h1, 5'h0, 3'h1, 9'h0));
			begin
				@(posedge sys_clk_i);
				reset_i <= 1'b1;
			end
		join
		pm.idle();
		repeat (2) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		pm.send(mk(0, 10, 32'h80007fff, 32'h0001ffff, 5'h0, 3'h1, 9'h0));
		pm.idle();
		repeat (3) @(posedge sys_clk_i);
		print_verdict();
	end
endmodule
`default_nettype wire
